/* File: capture_timer_pkg.sv */
package capture_timer_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] addr_low_match = 16'h7F14;
    localparam logic [15:0] addr_high_match = 16'h7F15;
    localparam logic [15:0] addr_timer_control = 16'h7F16;
    localparam logic [15:0] addr_divider_mode = 16'h7F17;
    localparam logic [7:0] reset_byte = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int pos_high_go = 7;
    localparam int pos_high_flag = 6;
    localparam int pos_high_ie = 5;
    localparam int pos_src_hi = 4;
    localparam int pos_src_lo = 3;
    localparam int pos_run = 2;
    localparam int pos_main_flag = 1;
    localparam int pos_main_ie = 0;
    localparam int pos_read_sel = 7;
    localparam int pos_length_sel = 6;
    localparam int pos_capture_en = 5;
    localparam int pos_period_hi = 4;

    // count source encodings
    typedef enum logic [1:0] {
        src_system = 2'b00,
        src_rc = 2'b01,
        src_crystal0 = 2'b10,
        src_crystal1 = 2'b11
    } count_source_t;

    // register bus request carried as one bundle
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } bus_req_t;

endpackage : capture_timer_pkg

/* File: dual_mode_capture_timer.sv */
// Functional notes
// RL1: two-bit source select picks system, RC, crystal0 or crystal1 as prescaler clock.
// RL2: prescaler counts while run is set, pulses at period match, then clears.
// RL3: low counter advances per prescaler pulse, started and stopped by run bit.
// RL4: high counter runs on run in 16-bit mode, on high-go in 8-bit mode.
// RL5: high counter clocks on low overflow in 16-bit mode, system clock in 8-bit.
// RL6: counters match against buffers, then clear; 16-bit needs all bits; stop clears.
// RL7: buffers follow match registers when stopped, reload at zero when running.
// RL8: software writes match data at most once per match period on slow sources.
// RL9: 16-bit period is (match+1) times (divider+1) times source period.
// RL10: 8-bit low period as above; high period is high match plus one cycles.
// RL11: run cleared halts at zero with buffer following register; set starts counting.
// RL12: main flag sets when running timer returns to zero; software clears it.
// RL13: high flag sets in 8-bit mode when high counter returns to zero.
// RL14: interrupt requested while main enable and main flag are both set.
// RL15: in 8-bit mode interrupt also requested on high enable and high flag.
// RL16: capture enable gates capture of counter data into capture registers.
// RL17: 16-bit mode, rising high flag captures both counter bytes at once.
// RL18: 8-bit mode, high flag captures low byte, main flag captures high byte.
// RL19: read select returns capture registers at the match register addresses.
// RL20: length select one gives two 8-bit counters, zero one 16-bit counter.
// RL21: interrupt request is a level held while any enabled flag is set; the code ignores an enabled high flag in 16-bit mode.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module dual_mode_capture_timer
    import capture_timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rc_clock,
    input wire logic first_crystal_clock,
    input wire logic second_crystal_clock,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [7:0] bus_rdata,
    output logic timer_irq
);

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    bus_req_t req;
    logic [7:0] low_match_data;
    logic [7:0] high_match_data;
    logic [7:0] timer_control;
    logic [7:0] divider_and_mode_control;
    logic [7:0] low_buffer;
    logic [7:0] high_buffer;
    logic [7:0] low_counter;
    logic [7:0] high_counter;
    logic [4:0] prescaler;
    logic [7:0] low_capture;
    logic [7:0] high_capture;
    logic [2:0] rc_sync;
    logic [2:0] x0_sync;
    logic [2:0] x1_sync;
    logic src_edge;
    logic run;
    logic high_go;
    logic eight_bit;
    logic high_runs;
    logic pre_match;
    logic low_hit;
    logic high_hit;
    logic low_step;
    logic high_step;
    logic main_set;
    logic high_set;
    logic sw_high_set;
    logic sw_main_set;
    logic main_rise;
    logic high_rise;
    logic ctl_write;

    assign req = '{addr: bus_addr, wdata: bus_wdata, write: bus_write, read: bus_read};

    assign run = timer_control[pos_run];
    assign high_go = timer_control[pos_high_go];
    assign eight_bit = divider_and_mode_control[pos_length_sel]; // RL20
    assign high_runs = eight_bit ? high_go : run; // RL4
    assign ctl_write = req.write && (req.addr == addr_timer_control);

    // ------------------------------------------------------------
    // source clock synchronisers and edge pick
    // ------------------------------------------------------------
    // bit 0 is first stage, read only by bit 1
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rc_sync <= 3'h0;
            x0_sync <= 3'h0;
            x1_sync <= 3'h0;
        end
        else
        begin
            rc_sync <= {rc_sync[1:0], rc_clock};
            x0_sync <= {x0_sync[1:0], first_crystal_clock};
            x1_sync <= {x1_sync[1:0], second_crystal_clock};
        end
    end

    // rising edge of the selected source, system clock every cycle
    always_comb
    begin
        case (count_source_t'(timer_control[pos_src_hi:pos_src_lo])) // RL1
            src_system: src_edge = 1'b1;
            src_rc: src_edge = rc_sync[1] & ~rc_sync[2];
            src_crystal0: src_edge = x0_sync[1] & ~x0_sync[2];
            src_crystal1: src_edge = x1_sync[1] & ~x1_sync[2];
            default: src_edge = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    assign pre_match = run && src_edge
        && (prescaler == divider_and_mode_control[pos_period_hi:0]); // RL2

    // a period lowered mid-count runs on to the wrap before it matches again
    always_ff @(posedge ref_clk)
    begin
        if (reset || !run)
            prescaler <= 5'h00; // RL2
        else if (pre_match)
            prescaler <= 5'h00; // RL2
        else if (src_edge)
            prescaler <= prescaler + 5'h01; // RL2
    end

    // ------------------------------------------------------------
    // counters and match detection
    // ------------------------------------------------------------
    // 16-bit mode needs both bytes equal to the buffers
    assign low_hit = eight_bit ? (low_counter == low_buffer)
        : ({high_counter, low_counter} == {high_buffer, low_buffer}); // RL6 RL9
    assign high_hit = high_counter == high_buffer; // RL6
    assign low_step = run && pre_match; // RL3
    // low overflow steps the high byte in 16-bit mode, system clock in 8-bit
    assign high_step = high_runs && (eight_bit ? 1'b1
        : (low_step && (low_counter == low_buffer))); // RL5 RL10

    // 16-bit wrap clears only on the full compare; the low byte rolls over
    always_ff @(posedge ref_clk)
    begin
        if (reset || !run)
            low_counter <= 8'h00; // RL11
        else if (low_step && low_hit)
            low_counter <= 8'h00; // RL6
        else if (low_step)
            low_counter <= low_counter + 8'h01; // RL3
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset || !high_runs)
            high_counter <= 8'h00; // RL4
        else if (high_step && (eight_bit ? high_hit : low_hit))
            high_counter <= 8'h00; // RL6
        else if (high_step)
            high_counter <= high_counter + 8'h01; // RL5
    end

    // ------------------------------------------------------------
    // match buffers
    // ------------------------------------------------------------
    // stopped: follow register; running: reload when the count sits at zero
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            low_buffer <= reset_byte;
        else if (!run || low_counter == 8'h00)
            low_buffer <= low_match_data; // RL7
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            high_buffer <= reset_byte;
        else if (!high_runs || high_counter == 8'h00)
            high_buffer <= high_match_data; // RL7
    end

    // full wrap: 16-bit whole wrap or 8-bit low wrap sets main flag
    assign main_set = low_step && low_hit; // RL12
    assign high_set = eight_bit && high_go && high_step && high_hit; // RL13
    assign sw_high_set = ctl_write && req.wdata[pos_high_flag];
    assign sw_main_set = ctl_write && req.wdata[pos_main_flag];
    assign main_rise = !timer_control[pos_main_flag] && (main_set || sw_main_set);
    assign high_rise = !timer_control[pos_high_flag] && (high_set || sw_high_set);

    // ------------------------------------------------------------
    // register writes and flags
    // ------------------------------------------------------------
    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            timer_control <= reset_byte;
        else
        begin
            if (ctl_write)
                timer_control <= req.wdata;
            if (main_set)
                timer_control[pos_main_flag] <= 1'b1; // RL12
            if (high_set)
                timer_control[pos_high_flag] <= 1'b1; // RL13
        end
    end

    // match data land at once; the buffers decide when they take effect
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            low_match_data <= reset_byte;
            high_match_data <= reset_byte;
            divider_and_mode_control <= reset_byte;
        end
        else if (req.write)
        begin
            if (req.addr == addr_low_match)
                low_match_data <= req.wdata;
            if (req.addr == addr_high_match)
                high_match_data <= req.wdata;
            if (req.addr == addr_divider_mode)
                divider_and_mode_control <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // captures follow a flag's rising edge; a flag already set captures nothing
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            low_capture <= reset_byte;
            high_capture <= reset_byte;
        end
        else if (divider_and_mode_control[pos_capture_en]) // RL16
        begin
            if (high_rise)
                low_capture <= low_counter; // RL17 RL18
            if (eight_bit ? main_rise : high_rise)
                high_capture <= high_counter; // RL17 RL18
        end
    end

    // ------------------------------------------------------------
    // read path and interrupt
    // ------------------------------------------------------------
    // read data live for one cycle only; idle cycles return zero
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            bus_rdata <= 8'h00;
        else if (req.read)
        begin
            case (req.addr)
                addr_low_match: bus_rdata <= divider_and_mode_control[pos_read_sel]
                    ? low_capture : low_match_data; // RL19
                addr_high_match: bus_rdata <= divider_and_mode_control[pos_read_sel]
                    ? high_capture : high_match_data; // RL19
                addr_timer_control: bus_rdata <= timer_control;
                addr_divider_mode: bus_rdata <= divider_and_mode_control;
                default: bus_rdata <= 8'h00;
            endcase
        end
        else
            bus_rdata <= 8'h00;
    end

    // level request, one cycle behind the flags
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            timer_irq <= 1'b0;
        else
            timer_irq <= (timer_control[pos_main_ie] && timer_control[pos_main_flag]) // RL14
                || (eight_bit && timer_control[pos_high_ie]
                && timer_control[pos_high_flag]); // RL15 RL21
    end

    // ------------------------------------------------------------
    // assertions: counting
    // ------------------------------------------------------------
    sequence s_stopped;
        !run;
    endsequence

    sequence s_high_stopped;
        !high_runs;
    endsequence

    a_stop_clears: assert property (@(posedge ref_clk) disable iff (reset) // RL11
        s_stopped ##1 1'b1 |-> low_counter == 8'h00 && prescaler == 5'h00)
        else $error("low counter not cleared when stopped");

    a_buffer_follows: assert property (@(posedge ref_clk) disable iff (reset) // RL7
        s_stopped |=> low_buffer == $past(low_match_data))
        else $error("low buffer not following register");

    a_high_stop: assert property (@(posedge ref_clk) disable iff (reset) // RL4
        s_high_stopped |=> high_counter == 8'h00 && high_buffer == $past(high_match_data))
        else $error("high counter not parked at zero");

    a_prescale_bound: assert property (@(posedge ref_clk) disable iff (reset) // RL2
        pre_match |=> prescaler == 5'h00)
        else $error("prescaler not cleared on match");

    a_prescale_step: assert property (@(posedge ref_clk) disable iff (reset) // RL2
        run && src_edge && !pre_match |=> prescaler == $past(prescaler) + 5'h01)
        else $error("prescaler missed a source edge");

    a_low_clear: assert property (@(posedge ref_clk) disable iff (reset) // RL6
        main_set |=> low_counter == 8'h00)
        else $error("low counter not cleared on match");

    // ------------------------------------------------------------
    // assertions: flags, capture, read path
    // ------------------------------------------------------------
    a_main_flag_set: assert property (@(posedge ref_clk) disable iff (reset) // RL12
        main_set |=> timer_control[pos_main_flag])
        else $error("main flag not set on wrap");

    a_high_flag_mode: assert property (@(posedge ref_clk) disable iff (reset) // RL13
        high_set |=> timer_control[pos_high_flag])
        else $error("high flag not set on wrap");

    // 16-bit mode raises the high flag by software only
    a_high_flag_guard: assert property (@(posedge ref_clk) disable iff (reset) // RL13
        !eight_bit && !sw_high_set |=> !$rose(timer_control[pos_high_flag]))
        else $error("high flag set by hardware in 16-bit mode");

    a_irq_level: assert property (@(posedge ref_clk) disable iff (reset) // RL14
        timer_control[pos_main_ie] && timer_control[pos_main_flag] |=> timer_irq)
        else $error("interrupt missing");

    a_irq_high: assert property (@(posedge ref_clk) disable iff (reset) // RL15
        eight_bit && timer_control[pos_high_ie] && timer_control[pos_high_flag] |=> timer_irq)
        else $error("high interrupt missing");

    a_irq_drop: assert property (@(posedge ref_clk) disable iff (reset) // RL21
        !(timer_control[pos_main_ie] && timer_control[pos_main_flag])
        && !(eight_bit && timer_control[pos_high_ie] && timer_control[pos_high_flag])
        |=> !timer_irq)
        else $error("interrupt held without an enabled flag");

    a_capture_off: assert property (@(posedge ref_clk) disable iff (reset) // RL16
        !divider_and_mode_control[pos_capture_en]
        |=> $stable(low_capture) && $stable(high_capture))
        else $error("capture while disabled");

    // both bytes are taken at the flag edge and show one cycle later
    a_capture_both: assert property (@(posedge ref_clk) disable iff (reset) // RL17
        divider_and_mode_control[pos_capture_en] && !eight_bit && high_rise
        |=> low_capture == $past(low_counter) && high_capture == $past(high_counter))
        else $error("16-bit capture missed a byte");

    a_capture_main: assert property (@(posedge ref_clk) disable iff (reset) // RL18
        divider_and_mode_control[pos_capture_en] && eight_bit && main_rise
        |=> high_capture == $past(high_counter))
        else $error("high byte not captured on main flag");

    a_read_capture: assert property (@(posedge ref_clk) disable iff (reset) // RL19
        req.read && req.addr == addr_low_match && divider_and_mode_control[pos_read_sel]
        |=> bus_rdata == $past(low_capture))
        else $error("read select ignored");

    a_read_high: assert property (@(posedge ref_clk) disable iff (reset) // RL19
        req.read && req.addr == addr_high_match && divider_and_mode_control[pos_read_sel]
        |=> bus_rdata == $past(high_capture))
        else $error("read select ignored on high byte");

endmodule : dual_mode_capture_timer

/* File: tb_dual_mode_capture_timer.sv */
`timescale 1ns/1ps
module tb_dual_mode_capture_timer;
    import capture_timer_pkg::*;

    // ------------------------------------------------------------
    // clocks, bus and counters
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic rc_clock = 1'b0;
    logic first_crystal_clock = 1'b0;
    logic second_crystal_clock = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [7:0] bus_rdata;
    logic timer_irq;
    int mismatches = 0;
    int compares = 0;
    logic [7:0] rv;

    // source clocks are whole multiples of the system period: 7, 5 and 3,
    // shifted 10 ns so that no source edge meets a system edge
    always #50 ref_clk = ~ref_clk;
    initial #10 forever #350 rc_clock = ~rc_clock;
    initial #10 forever #250 first_crystal_clock = ~first_crystal_clock;
    initial #10 forever #150 second_crystal_clock = ~second_crystal_clock;

    dual_mode_capture_timer dut (
        .ref_clk(ref_clk),
        .reset(reset),
        .rc_clock(rc_clock),
        .first_crystal_clock(first_crystal_clock),
        .second_crystal_clock(second_crystal_clock),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_write(bus_write),
        .bus_read(bus_read),
        .bus_rdata(bus_rdata),
        .timer_irq(timer_irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge ref_clk);
        bus_write <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data stands in the following cycle
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge ref_clk);
        bus_read <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd

    // bounded wait for the request line, counting edges
    task automatic wait_irq(output int n);
        n = 0;
        while (timer_irq !== 1'b1 && n < 3000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 3000)
        begin
            $display("FAIL %0t request never came", $time);
            mismatches++;
            summarize();
        end
    endtask : wait_irq

    // program, run, and time one match-to-match interval
    task automatic period(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] dv,
                          input logic [7:0] ctl, input int exp);
        int a;
        int b;
        wr(addr_low_match, lo);
        wr(addr_high_match, hi);
        wr(addr_divider_mode, dv);
        wr(addr_timer_control, ctl);
        wait_irq(a);
        wr(addr_timer_control, ctl);
        repeat (2) @(posedge ref_clk);
        #1;
        wait_irq(b);
        check(16'(b + 4), 16'(exp));
        wr(addr_timer_control, 8'h00);
    endtask : period

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset values, read-back, unmapped place, level request
    task automatic t_regs();
        rd(addr_low_match, rv);
        check(16'(rv), 16'(reset_byte));
        rd(addr_high_match, rv);
        check(16'(rv), 16'(reset_byte));
        rd(addr_timer_control, rv);
        check(16'(rv), 16'(reset_byte));
        rd(addr_divider_mode, rv);
        check(16'(rv), 16'(reset_byte));
        wr(16'h7F18, 8'hFF);
        rd(16'h7F18, rv);
        check(16'(rv), 16'h0000);
        wr(addr_low_match, 8'hA5);
        wr(addr_high_match, 8'h5A);
        wr(addr_divider_mode, 8'h1F);
        rd(addr_high_match, rv);
        check(16'(rv), 16'h005A);
        rd(addr_divider_mode, rv);
        check(16'(rv), 16'h001F);
        wr(addr_timer_control, 8'h43);
        repeat (2) @(posedge ref_clk);
        #1;
        check(16'(timer_irq), 16'h0001);
        wr(addr_timer_control, 8'h42);
        repeat (2) @(posedge ref_clk);
        #1;
        check(16'(timer_irq), 16'h0000);
        rd(addr_timer_control, rv);
        check(16'(rv), 16'h0042);
        wr(addr_timer_control, 8'h00);
        $display("test registers done");
    endtask : t_regs

    // match periods in both lengths and from every source
    task automatic t_periods();
        int ratio [4] = '{1, 7, 5, 3};
        period(8'h05, 8'h00, 8'h02, 8'h05, 18);
        period(8'h02, 8'h01, 8'h00, 8'h05, 259);
        period(8'h05, 8'h00, 8'h62, 8'h05, 18);
        period(8'h00, 8'h07, 8'h40, 8'hA0, 8);
        for (int s = 0; s < 4; s++)
        begin
            period(8'h03, 8'h00, 8'h00, 8'(8'h05 | (s << 3)), 4 * ratio[s]);
        end
        $display("test periods done");
    endtask : t_periods

    // capture by software flag, gated by enable, read through select
    task automatic t_capture();
        wr(addr_low_match, 8'hFF);
        wr(addr_divider_mode, 8'h7F);
        wr(addr_timer_control, 8'h04);
        repeat (112) @(posedge ref_clk);
        wr(addr_timer_control, 8'h44);
        wr(addr_divider_mode, 8'hFF);
        rd(addr_low_match, rv);
        check(16'(rv), 16'h0003);
        rd(addr_high_match, rv);
        check(16'(rv), 16'h0000);
        wr(addr_divider_mode, 8'hDF);
        wr(addr_timer_control, 8'h04);
        repeat (64) @(posedge ref_clk);
        wr(addr_timer_control, 8'h44);
        rd(addr_low_match, rv);
        check(16'(rv), 16'h0003);
        wr(addr_divider_mode, 8'h5F);
        rd(addr_low_match, rv);
        check(16'(rv), 16'h00FF);
        wr(addr_timer_control, 8'h00);
        wr(addr_high_match, 8'h02);
        wr(addr_divider_mode, 8'hA0);
        wr(addr_timer_control, 8'h04);
        repeat (299) @(posedge ref_clk);
        wr(addr_timer_control, 8'h44);
        rd(addr_low_match, rv);
        check(16'(rv), 16'h002C);
        rd(addr_high_match, rv);
        check(16'(rv), 16'h0001);
        wr(addr_timer_control, 8'h00);
        $display("test capture done");
    endtask : t_capture

    // verdict and end of run
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_periods();
        t_capture();
        summarize();
    end
endmodule : tb_dual_mode_capture_timer
